// ---- test/test_timer16_waveform_mode_control.sv ----
// Self-checking bench of the timer waveform and mode control
`timescale 1ns/1ps
`include "twm_cfg.svh"

module test_timer16_waveform_mode_control;
  import twm_pkg::*;
  // ****
  // Signals
  // ****
  logic             clk;
  logic             sys_rst;
  logic [7:0]       regAddr;
  logic [7:0]       regWrData;
  logic             regWrStb;
  logic             regRdStb;
  logic [7:0]       regRdData;
  logic             timerTick;
  logic [1:0]       modeHi;
  logic [2:0][15:0] cmpBuf;
  logic [15:0]      captureValue;
  logic [2:0]       portDir;
  logic [2:0]       portData;
  twm_pin_s         pins;
  logic             overflowPulse;
  logic [15:0]      counterValue;
  logic [2:0]       padLevel;
  logic [7:0]       rdVal;
  int               miscompares = 0;
  int               n_compared = 0;
  int               ovfCount = 0;

  twm_timer16_wave_ctrl twm_timer16_wave_ctrl_i (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .timerTick(timerTick), .modeHi(modeHi),
    .cmpBuf(cmpBuf), .captureValue(captureValue), .portDir(portDir),
    .portData(portData), .pins(pins), .overflowPulse(overflowPulse),
    .counterValue(counterValue)
  );

  twm_pad_model twm_pad_model_i (
    .clk(clk), .pins(pins), .padLevel(padLevel)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (overflowPulse === 1'b1) begin
      ovfCount++;
    end
  end

  // ****
  // Tasks
  // ****
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic doReset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    @(negedge clk);
    rdVal = regRdData;
  endtask

  task automatic setup(input logic [3:0] m, input logic [5:0] com);
    @(posedge clk);
    modeHi <= m[3:2];
    wr(`TWM_CTRL_ADDR, {com, m[1:0]});
  endtask

  // Ticks until the count shows v, then one tick more
  task automatic runTo(input logic [15:0] v);
    int i;
    @(posedge clk);
    timerTick <= 1'b1;
    for (i = 0; i < 3000; i++) begin
      @(negedge clk);
      if (counterValue === v) break;
    end
    @(posedge clk);
    timerTick <= 1'b0;
    @(negedge clk);
    if (i == 3000) begin
      miscompares++;
      complete_run();
    end
  endtask

  task automatic topCase(input logic [3:0] m, input logic [15:0] top,
                         input logic [15:0] nxt, input int ovf);
    int n;
    doReset();
    setup(m, 6'b000000);
    n = ovfCount;
    runTo(top);
    chk("count after top", nxt, counterValue);
    repeat (2) @(negedge clk);
    chk("overflow", 16'(ovf), 16'(ovfCount - n));
  endtask

  task automatic tReg();
    rd(`TWM_CTRL_ADDR);
    chk("ctrl reset", 16'h0000, 16'(rdVal));
    chk("enable reset", 16'h0007, 16'(pins.enN));
    wr(`TWM_CTRL_ADDR, 8'hA5);
    rd(`TWM_CTRL_ADDR);
    chk("ctrl rw", 16'h00A5, 16'(rdVal));
    @(negedge clk);
    chk("read idle", 16'h0000, 16'(regRdData));
    wr(8'h81, 8'h3C);
    rd(8'h81);
    chk("unmapped", 16'h0000, 16'(rdVal));
    rd(`TWM_CTRL_ADDR);
    chk("ctrl kept", 16'h00A5, 16'(rdVal));
    // Write then read with no gap
    @(posedge clk);
    regAddr <= `TWM_CTRL_ADDR;
    regWrData <= 8'h5A;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    @(negedge clk);
    chk("ctrl back to back", 16'h005A, 16'(regRdData));
  endtask

  task automatic tTake();
    doReset();
    @(posedge clk);
    portData <= 3'b101;
    portDir <= 3'b010;
    repeat (3) @(negedge clk);
    chk("port data", 16'h0005, 16'(pins.level));
    chk("port dir", 16'h0005, 16'(pins.enN));
    @(posedge clk);
    portData <= 3'b111;
    portDir <= 3'b000;
    setup(4'h0, 6'b001100);
    repeat (3) @(negedge clk);
    chk("takeover", 16'h0005, 16'(pins.level));
    chk("dir kept", 16'h0007, 16'(pins.enN));
  endtask

  task automatic tNonPwm();
    doReset();
    @(posedge clk);
    portDir <= 3'b111;
    cmpBuf <= {16'h0007, 16'h0006, 16'h0005};
    setup(4'h0, 6'b110110);
    runTo(16'h0008);
    repeat (2) @(negedge clk);
    chk("nonpwm pad", 16'h0003, 16'(padLevel));
    @(posedge clk);
    cmpBuf <= {16'h0022, 16'h0021, 16'h0020};
    setup(4'h0, 6'b100111);
    runTo(16'h0024);
    repeat (2) @(negedge clk);
    chk("nonpwm again", 16'h0004, 16'(padLevel));
  endtask

  task automatic tFast();
    int n;
    doReset();
    @(posedge clk);
    cmpBuf <= {16'h00FF, 16'h0010, 16'h0010};
    setup(4'h5, 6'b101110);
    n = ovfCount;
    runTo(16'h00FF);
    repeat (2) @(negedge clk);
    chk("fast top", 16'h0005, 16'(padLevel));
    chk("fast ovf", 16'h0001, 16'(ovfCount - n));
    runTo(16'h0011);
    repeat (2) @(negedge clk);
    chk("fast match", 16'h0006, 16'(padLevel));
    runTo(16'h00FF);
    repeat (2) @(negedge clk);
    chk("fast equal top", 16'h0005, 16'(padLevel));
    chk("fast ovf again", 16'h0002, 16'(ovfCount - n));
  endtask

  task automatic tDual();
    int n;
    doReset();
    @(posedge clk);
    cmpBuf <= {16'h0000, 16'h0040, 16'h0040};
    setup(4'h1, 6'b101110);
    n = ovfCount;
    runTo(16'h00FF);
    runTo(16'h0030);
    repeat (2) @(negedge clk);
    chk("dual down", 16'h0001, 16'(padLevel));
    chk("dual no ovf", 16'h0000, 16'(ovfCount - n));
    runTo(16'h0050);
    repeat (2) @(negedge clk);
    chk("dual up", 16'h0002, 16'(padLevel));
    chk("dual ovf", 16'h0001, 16'(ovfCount - n));
  endtask

  task automatic tToggle();
    logic [5:0][3:0] offM;
    logic [1:0][3:0] onM;
    logic            a;
    offM = 24'h567123;
    onM = 8'hFA;
    @(posedge clk);
    portData <= 3'b101;
    cmpBuf <= {16'h0000, 16'h0000, 16'h0018};
    captureValue <= 16'h0020;
    for (int i = 0; i < 6; i++) begin
      doReset();
      setup(offM[i], 6'b010101);
      runTo(16'h0020);
      repeat (2) @(negedge clk);
      chk("toggle off", 16'h0005, 16'(padLevel));
    end
    for (int i = 0; i < 2; i++) begin
      doReset();
      setup(onM[i], 6'b010101);
      runTo(16'h0010);
      repeat (2) @(negedge clk);
      a = padLevel[0];
      runTo(16'h0018);
      repeat (2) @(negedge clk);
      chk("toggle a", 16'({~a}), 16'(padLevel[0]));
      chk("toggle bc", 16'h0002, 16'(padLevel[2:1]));
    end
  endtask

  task automatic tTop();
    int n;
    @(posedge clk);
    cmpBuf <= {16'h0000, 16'h0000, 16'h0030};
    captureValue <= 16'h0028;
    topCase(4'h4, 16'h0030, 16'h0000, 0);
    topCase(4'hC, 16'h0028, 16'h0000, 0);
    topCase(4'h8, 16'h0028, 16'h0027, 0);
    @(posedge clk);
    cmpBuf <= {16'h0000, 16'h0011, 16'h0030};
    n = ovfCount;
    runTo(`TWM_BOTTOM);
    repeat (2) @(negedge clk);
    chk("pfc bottom ovf", 16'h0001, 16'(ovfCount - n));
    topCase(4'hE, 16'h0028, 16'h0000, 1);
    topCase(4'h3, 16'h03FF, 16'h03FE, 0);
    topCase(4'h7, 16'h03FF, 16'h0000, 1);
    // Reserved mode 13 kept out of stimulus
    topCase(4'h0, 16'h0030, 16'h0031, 0);
  endtask

  initial begin
    sys_rst = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    timerTick = 1'b0;
    modeHi = 2'h0;
    cmpBuf = '0;
    captureValue = 16'h0000;
    portDir = 3'h0;
    portData = 3'h0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    tReg();
    tTake();
    tNonPwm();
    tFast();
    tDual();
    tToggle();
    tTop();
    complete_run();
  end
endmodule

// ---- test/twm_pad_model.sv ----
// Pad model of the three waveform pins behind the port logic
`timescale 1ns/1ps

module twm_pad_model (
  input  wire logic              clk,
  input  wire twm_pkg::twm_pin_s pins,
  output      logic [2:0]        padLevel
);
  import twm_pkg::*;
  // ****
  // Pad resolution
  // ****
  logic [2:0] lastLevel_q;
  assign padLevel = (~pins.enN & pins.level) | (pins.enN & ~lastLevel_q);
  // Released pad keeps the inverse of its last driven level
  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (!pins.enN[i]) begin
        lastLevel_q[i] <= pins.level[i];
      end
    end
  end
endmodule

// ---- verilog/twm_cfg.svh ----
// Constants of the 16-bit timer waveform and mode control block
`ifndef TWM_CFG_SVH
`define TWM_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define TWM_CTRL_ADDR   8'h80
`define TWM_CTRL_RST    8'h00
`define TWM_RD_IDLE     8'h00

// ****************************************
// Control register fields
// ****************************************
`define TWM_COM_LSB(ch) (6 - 2 * (ch))
`define TWM_WGM_MSB     1
`define TWM_WGM_LSB     0
`define TWM_COM_OFF     2'b00
`define TWM_COM_TOGGLE  2'b01
`define TWM_COM_CLEAR   2'b10
`define TWM_COM_SET     2'b11

// ****************************************
// Counter values, pin enable and channel constants
// ****************************************
`define TWM_BOTTOM      16'h0000
`define TWM_ONE         16'h0001
`define TWM_TOP8        16'h00FF
`define TWM_TOP9        16'h01FF
`define TWM_TOP10       16'h03FF
`define TWM_MAX         16'hFFFF
`define TWM_EN_OFF      3'h7
`define TWM_CH_A        0
`define TWM_CHANNELS    3

`endif

// ---- verilog/twm_pkg.sv ----
// Types of the 16-bit timer waveform and mode control block
package twm_pkg;

  // ****************************************
  // Waveform generation modes
  // ****************************************
  typedef enum logic [3:0] {
    MODE_NORMAL  = 4'b0000,
    MODE_PC8     = 4'b0001,
    MODE_PC9     = 4'b0010,
    MODE_PC10    = 4'b0011,
    MODE_CTC_CMP = 4'b0100,
    MODE_FAST8   = 4'b0101,
    MODE_FAST9   = 4'b0110,
    MODE_FAST10  = 4'b0111,
    MODE_PFC_CAP = 4'b1000,
    MODE_PFC_CMP = 4'b1001,
    MODE_PC_CAP  = 4'b1010,
    MODE_PC_CMP  = 4'b1011,
    MODE_CTC_CAP = 4'b1100,
    MODE_RSVD    = 4'b1101,
    MODE_FAST_CAP = 4'b1110,
    MODE_FAST_CMP = 4'b1111
  } twm_mode_e;

  typedef enum logic [1:0] {
    CLS_NONPWM = 2'b00,
    CLS_FAST   = 2'b01,
    CLS_DUAL   = 2'b10
  } twm_class_e;

  typedef enum logic [1:0] {
    UPD_NOW    = 2'b00,
    UPD_TOP    = 2'b01,
    UPD_BOTTOM = 2'b10
  } twm_upd_e;

  typedef enum logic [1:0] {
    OVF_MAX    = 2'b00,
    OVF_TOP    = 2'b01,
    OVF_BOTTOM = 2'b10
  } twm_ovf_e;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [2:0] level;
    logic [2:0] enN;
  } twm_pin_s;

  typedef struct packed {
    logic [7:0]       ctrl;
    logic [15:0]      count;
    logic             down;
    logic [2:0][15:0] cmp;
    logic [2:0]       wave;
    logic             ovf;
    logic [7:0]       rdData;
    twm_pin_s         pin;
  } twm_state_s;

endpackage

// ---- verilog/twm_timer16_wave_ctrl.sv ----
// 16-bit timer output mode and waveform generation mode control
// Function
// [RULE1] Control bits 7:6, 5:4, 3:2 hold output modes of channels A, B, C.
// [RULE2] A nonzero output mode hands the channel's pin to its waveform.
// [RULE3] Pin driver enabled only when the port direction bit says output.
// [RULE4] Output mode meaning depends on non-PWM, fast or dual-slope class.
// [RULE5] Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// [RULE6] Fast PWM: 10 clear on match, set at TOP; 11 the reverse.
// [RULE7] Fast PWM 01 toggles A only in modes 14, 15; B, C off.
// [RULE8] Fast PWM with compare equal TOP: match ignored, only TOP action.
// [RULE9] Dual slope: 10 clears on up match, sets on down; 11 reverse.
// [RULE10] Dual slope 01 toggles A only in modes 8 to 11; B, C off.
// [RULE11] Control bits 1:0 are the low half of the waveform mode.
// [RULE12] Modes 0, 4, 12: TOP fixed or A or capture, immediate update.
// [RULE13] Modes 1-3, 10, 11: phase correct, update at TOP, flag at BOTTOM.
// [RULE14] Modes 5-7, 14, 15: fast PWM, update and flag at TOP.
// [RULE15] Modes 8, 9: update and flag at BOTTOM, TOP capture or A.
// [RULE16] Upper mode bits come from the second timer control register.
// [RULE17] Dual slope: compare at BOTTOM holds low, at TOP holds high.
// [RULE18] Software never selects mode 13; treated like normal mode.
// [RULE19] Control register resets to zero, outputs disconnected.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "twm_cfg.svh"

module twm_timer16_wave_ctrl (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic [7:0]           regAddr,
  input  wire logic [7:0]           regWrData,
  input  wire logic                 regWrStb,
  input  wire logic                 regRdStb,
  output      logic [7:0]           regRdData,
  input  wire logic                 timerTick,
  input  wire logic [1:0]           modeHi,
  input  wire logic [2:0][15:0]     cmpBuf,
  input  wire logic [15:0]          captureValue,
  input  wire logic [2:0]           portDir,
  input  wire logic [2:0]           portData,
  output      twm_pkg::twm_pin_s    pins,
  output      logic                 overflowPulse,
  output      logic [15:0]          counterValue
);
  import twm_pkg::*;

  // ****************************************
  // State
  // ****************************************
  twm_state_s       st_q;
  twm_state_s       st_d;
  twm_mode_e        mode;
  twm_class_e       cls;
  twm_upd_e         upd;
  twm_ovf_e         ovfAt;
  logic [15:0]      top;
  logic             aToggleOk;
  logic             atTop;
  logic             atBottom;
  logic             doUpdate;
  logic [2:0][1:0]  com;
  logic [2:0]       match;
  logic [2:0]       conn;

  // ****************************************
  // Mode decode
  // ****************************************
  always_comb begin
    // [RULE16] Mode upper half joined
    // [RULE11] Mode lower half from control
    mode = twm_mode_e'({modeHi,
                        st_q.ctrl[`TWM_WGM_MSB:`TWM_WGM_LSB]});
    cls = CLS_NONPWM;
    upd = UPD_NOW;
    ovfAt = OVF_MAX;
    top = `TWM_MAX;
    aToggleOk = 1'b0;
    // [RULE4] Mode class selection
    unique case (mode)
      // [RULE12] Non-PWM counting modes
      // [RULE18] Reserved mode as normal
      MODE_NORMAL, MODE_RSVD: begin
        top = `TWM_MAX;
      end
      MODE_CTC_CMP: begin
        top = st_q.cmp[`TWM_CH_A];
      end
      MODE_CTC_CAP: begin
        top = captureValue;
      end
      // [RULE13] Phase correct modes
      MODE_PC8, MODE_PC9, MODE_PC10, MODE_PC_CAP, MODE_PC_CMP: begin
        cls = CLS_DUAL;
        upd = UPD_TOP;
        ovfAt = OVF_BOTTOM;
        aToggleOk = mode == MODE_PC_CAP || mode == MODE_PC_CMP;
        if (mode == MODE_PC8) begin
          top = `TWM_TOP8;
        end else if (mode == MODE_PC9) begin
          top = `TWM_TOP9;
        end else if (mode == MODE_PC10) begin
          top = `TWM_TOP10;
        end else if (mode == MODE_PC_CAP) begin
          top = captureValue;
        end else begin
          top = st_q.cmp[`TWM_CH_A];
        end
      end
      // [RULE14] Fast PWM modes
      MODE_FAST8, MODE_FAST9, MODE_FAST10, MODE_FAST_CAP,
      MODE_FAST_CMP: begin
        cls = CLS_FAST;
        upd = UPD_TOP;
        ovfAt = OVF_TOP;
        aToggleOk = mode == MODE_FAST_CAP || mode == MODE_FAST_CMP;
        if (mode == MODE_FAST8) begin
          top = `TWM_TOP8;
        end else if (mode == MODE_FAST9) begin
          top = `TWM_TOP9;
        end else if (mode == MODE_FAST10) begin
          top = `TWM_TOP10;
        end else if (mode == MODE_FAST_CAP) begin
          top = captureValue;
        end else begin
          top = st_q.cmp[`TWM_CH_A];
        end
      end
      // [RULE15] Phase and frequency correct modes
      MODE_PFC_CAP, MODE_PFC_CMP: begin
        cls = CLS_DUAL;
        upd = UPD_BOTTOM;
        ovfAt = OVF_BOTTOM;
        aToggleOk = 1'b1;
        top = (mode == MODE_PFC_CAP) ? captureValue
                                     : st_q.cmp[`TWM_CH_A];
      end
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    atTop = st_q.count == top;
    atBottom = st_q.count == `TWM_BOTTOM;

    // Register port
    // [RULE1] Control register write
    if (regWrStb && regAddr == `TWM_CTRL_ADDR) begin
      st_d.ctrl = regWrData;
    end
    st_d.rdData = (regRdStb && regAddr == `TWM_CTRL_ADDR) ? st_q.ctrl
                                                         : `TWM_RD_IDLE;

    // Counter sequence
    if (timerTick) begin
      if (cls == CLS_DUAL) begin
        if (!st_q.down) begin
          st_d.down = atTop;
          st_d.count = atTop ? st_q.count - `TWM_ONE
                             : st_q.count + `TWM_ONE;
        end else begin
          st_d.down = !atBottom;
          st_d.count = atBottom ? st_q.count + `TWM_ONE
                                : st_q.count - `TWM_ONE;
        end
      end else begin
        st_d.down = 1'b0;
        st_d.count = atTop ? `TWM_BOTTOM : st_q.count + `TWM_ONE;
      end
    end

    // [RULE13] Overflow event by mode
    unique case (ovfAt)
      OVF_MAX:    st_d.ovf = timerTick && st_q.count == `TWM_MAX;
      OVF_TOP:    st_d.ovf = timerTick && atTop;
      OVF_BOTTOM: st_d.ovf = timerTick && st_q.down && atBottom;
      default:    st_d.ovf = 1'b0;
    endcase

    // [RULE12] Compare buffer update point
    unique case (upd)
      UPD_NOW:    doUpdate = 1'b1;
      UPD_TOP:    doUpdate = timerTick && atTop;
      UPD_BOTTOM: doUpdate = timerTick && st_q.down && atBottom;
      default:    doUpdate = 1'b0;
    endcase
    if (doUpdate) begin
      st_d.cmp = cmpBuf;
    end

    // Channel waveforms
    for (int i = 0; i < `TWM_CHANNELS; i++) begin
      // [RULE1] Output mode field per channel
      com[i] = st_q.ctrl[`TWM_COM_LSB(i) +: 2];
      match[i] = timerTick && st_q.count == st_q.cmp[i];
      // [RULE7] Toggle only on A in allowed modes
      // [RULE10] Dual slope toggle on A only
      conn[i] = com[i][1] || (com[i] == `TWM_COM_TOGGLE &&
                (cls == CLS_NONPWM || (i == `TWM_CH_A && aToggleOk)));
      if (com[i] == `TWM_COM_TOGGLE) begin
        if (conn[i] && match[i]) begin
          st_d.wave[i] = !st_q.wave[i];
        end
      end else if (com[i][1]) begin
        if (cls == CLS_NONPWM) begin
          // [RULE5] Clear or set on match
          if (match[i]) begin
            st_d.wave[i] = com[i][0];
          end
        end else if (cls == CLS_FAST) begin
          // [RULE6] Set or clear at TOP
          // [RULE8] Match at TOP ignored
          if (timerTick && atTop) begin
            st_d.wave[i] = !com[i][0];
          end else if (match[i] && st_q.cmp[i] != top) begin
            st_d.wave[i] = com[i][0];
          end
        end else begin
          // [RULE17] Extreme compare values held
          // [RULE9] Direction-dependent match action
          if (st_q.cmp[i] == `TWM_BOTTOM) begin
            st_d.wave[i] = com[i][0];
          end else if (st_q.cmp[i] == top) begin
            st_d.wave[i] = !com[i][0];
          end else if (match[i]) begin
            st_d.wave[i] = st_q.down ? !com[i][0] : com[i][0];
          end
        end
      end
      // [RULE2] Waveform replaces port data
      st_d.pin.level[i] = conn[i] ? st_d.wave[i] : portData[i];
      // [RULE3] Driver follows port direction
      st_d.pin.enN[i] = !portDir[i];
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      // [RULE19] All zero, pins released
      st_q <= '0;
      st_q.pin.enN <= `TWM_EN_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  assign regRdData = st_q.rdData;
  assign pins = st_q.pin;
  assign overflowPulse = st_q.ovf;
  assign counterValue = st_q.count;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_ctrl_readback: assert property ( // [RULE1]
    (regWrStb && regAddr == `TWM_CTRL_ADDR) ##1
    (regRdStb && regAddr == `TWM_CTRL_ADDR)
    |=> regRdData == $past(regWrData, 2))
    else $error("control readback mismatch");

  chk_pin_port_mode: assert property ( // [RULE2]
    com[0] == `TWM_COM_OFF |=> pins.level[0] == $past(portData[0]))
    else $error("disconnected pin not following port data");

  chk_pin_driver_dir: assert property ( // [RULE3]
    1'b1 |=> pins.enN == ~$past(portDir))
    else $error("pin driver not following direction");

  chk_nonpwm_clear: assert property ( // [RULE5]
    (cls == CLS_NONPWM && com[0] == `TWM_COM_CLEAR && match[0])
    |=> !st_q.wave[0] && !pins.level[0])
    else $error("non-PWM clear on match failed");

  chk_fast_top_set: assert property ( // [RULE6]
    (cls == CLS_FAST && com[0] == `TWM_COM_CLEAR && timerTick && atTop)
    |=> st_q.wave[0])
    else $error("fast PWM set at TOP failed");

  chk_fast_b_toggle_off: assert property ( // [RULE7]
    (cls == CLS_FAST && com[1] == `TWM_COM_TOGGLE)
    |=> pins.level[1] == $past(portData[1]))
    else $error("fast PWM channel B toggle not disconnected");

  chk_fast_top_match: assert property ( // [RULE8]
    (cls == CLS_FAST && com[2] == `TWM_COM_CLEAR && timerTick && atTop &&
     st_q.cmp[2] == top) |=> st_q.wave[2])
    else $error("fast PWM match at TOP not ignored");

  chk_dual_up_clear: assert property ( // [RULE9]
    (cls == CLS_DUAL && com[0] == `TWM_COM_CLEAR && match[0] &&
     !st_q.down && st_q.cmp[0] != `TWM_BOTTOM && st_q.cmp[0] != top)
    |=> !st_q.wave[0])
    else $error("dual slope up-count clear failed");

  chk_fast_overflow: assert property ( // [RULE14]
    (cls == CLS_FAST && timerTick && atTop) |=> overflowPulse)
    else $error("fast PWM overflow missing at TOP");

  chk_pfc_update: assert property ( // [RULE15]
    (upd == UPD_BOTTOM && timerTick && st_q.down && atBottom)
    |=> st_q.cmp[1] == $past(cmpBuf[1]))
    else $error("compare not updated at BOTTOM");

  chk_bottom_low: assert property ( // [RULE17]
    (cls == CLS_DUAL && com[0] == `TWM_COM_CLEAR &&
     st_q.cmp[0] == `TWM_BOTTOM) |=> !st_q.wave[0])
    else $error("compare at BOTTOM not held low");

endmodule
